//--- serial_prog_regs.vh
`ifndef SERIAL_PROG_REGS_VH
`define SERIAL_PROG_REGS_VH

// Core clock and wait times
`define CLK_PERIOD_NS      5
`define FLASH_WAIT_US      4500
`define EEPROM_WAIT_US     3600
`define ERASE_WAIT_US      9000
`define US_TO_CYC(us) (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_WAIT_CYC     `US_TO_CYC(`FLASH_WAIT_US)
`define EEPROM_WAIT_CYC    `US_TO_CYC(`EEPROM_WAIT_US)
`define ERASE_WAIT_CYC     `US_TO_CYC(`ERASE_WAIT_US)
`define TIMER_W            21

// Array geometry
`define FLASH_AW           13
`define FLASH_WORDS        8192
`define PAGE_AW            6
`define PAGE_WORDS         64
`define EE_AW              10
`define EE_BYTES           1024
`define EE_PAGE_AW         2
`define EE_PAGE_BYTES      4

// Instruction bytes
`define INS_PREFIX         8'hAC
`define INS_ENABLE2        8'h53
`define INS_ERASE2         8'h80
`define INS_WLOCK2         8'hE0
`define INS_WFUSE2         8'hA0
`define INS_WFUSEH2        8'hA8
`define INS_WFUSEX2        8'hA4
`define INS_POLL           8'hF0
`define INS_EXT_ADDR       8'h4D
`define INS_LOAD_HI        8'h48
`define INS_LOAD_LO        8'h40
`define INS_EE_LOAD        8'hC1
`define INS_FLASH_COMMIT   8'h4C
`define INS_EE_WRITE       8'hC0
`define INS_EE_COMMIT      8'hC2
`define INS_RD_HI          8'h28
`define INS_RD_LO          8'h20
`define INS_RD_EE          8'hA0
`define INS_RD_LOCK        8'h58
`define INS_RD_FUSE        8'h50
`define INS_RD_SIG         8'h30
`define INS_RD_CAL         8'h38
`define SEL_HIGH           8'h08

// Write job layout: {op, addr, data}
`define JOB_W              24
`define JOB_OP             23:21
`define JOB_ADDR           20:8
`define JOB_DATA           7:0
`define OP_LOAD_LO         3'h0
`define OP_LOAD_HI         3'h1
`define OP_EE_LOAD         3'h2
`define OP_FLASH_COMMIT    3'h3
`define OP_EE_WRITE        3'h4
`define OP_EE_COMMIT       3'h5
`define OP_ERASE           3'h6
`define OP_FUSE_WRITE      3'h7
`define FIFO_DEPTH         8

// Fuse select in job address
`define FSEL_LOCK          2'h0
`define FSEL_LOW           2'h1
`define FSEL_HIGH          2'h2
`define FSEL_EXT           2'h3

// Reset values, all unprogrammed
`define LOCK_RESET         8'hFF
`define FUSE_LOW_RESET     8'hFF
`define FUSE_HIGH_RESET    8'hFF
`define FUSE_EXT_RESET     8'hFF
`define ERASED_BYTE        8'hFF
`define ERASED_WORD        16'hFFFF

`endif

//--- job_fifo.v
`timescale 1ns/1ps
module job_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // job_fifo

//--- serial_prog_port.v
`timescale 1ns/1ps
`include "serial_prog_regs.vh"

//Contract
//- Programming works only while the reset pin is held low.
//- Nothing but programming enable is obeyed until enable has executed.
//- EEPROM writes erase the location automatically before writing.
//- Chip erase sets all Flash and EEPROM locations to ones.
//- Input bits are sampled on the rising serial clock edge.
//- Output bits change on the falling serial clock edge.
//- Second enable byte echoes during third byte; programmer retries on mismatch.
//- Page buffer loads one byte per instruction at six address bits.
//- Page write commits Flash buffer at seven high address bits; 4.5 ms.
//- EEPROM byte write stores one location; programmer waits 3.6 ms.
//- EEPROM page commit alters only loaded byte locations.
//- Read instructions return the addressed content in the fourth byte.
//- Releasing reset high leaves programming mode.
//- Four-byte instructions; decode enable and busy poll.
//- Decode Flash high and low loads, EEPROM load, extended address.
//- Decode Flash high and low reads and EEPROM read.
//- Decode lock, fuse, signature and calibration reads.
//- Busy poll reports pending operation in bit zero.
//- Decode Flash commit, EEPROM write, EEPROM commit, lock and fuse writes.
//- Fuse and lock bits read zero when programmed.
module serial_prog_port #(
  parameter [`TIMER_W-1:0] FLASH_WAIT_CYCLES  = `FLASH_WAIT_CYC,
  parameter [`TIMER_W-1:0] EEPROM_WAIT_CYCLES = `EEPROM_WAIT_CYC,
  parameter [`TIMER_W-1:0] ERASE_WAIT_CYCLES  = `ERASE_WAIT_CYC,
  // Arbitrary identity values
  parameter [7:0]          SIGNATURE_0        = 8'h5A,
  parameter [7:0]          SIGNATURE_1        = 8'h01,
  parameter [7:0]          SIGNATURE_2        = 8'h02,
  parameter [7:0]          CALIBRATION        = 8'h80
) (
  input  wire clock,
  input  wire reset,
  input  wire prog_reset_n_pin,
  input  wire sck_pin,
  input  wire mosi_pin,
  output reg  miso,
  output wire miso_oe_n,
  output wire prog_mode,
  output wire write_pending_flag
);
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_ERASE = 2'b10;

  reg [2:0]  sck_sync_reg;
  reg [1:0]  mosi_sync_reg;
  reg [1:0]  rst_sync_reg;
  reg [6:0]  rx_reg;
  reg [2:0]  bit_cnt_reg;
  reg [1:0]  byte_idx_reg;
  reg [7:0]  b1_reg, b2_reg, b3_reg;
  reg [7:0]  tx_reg;
  reg [7:0]  tx_load_reg;
  reg        tx_pending_reg;
  reg        enabled_reg;
  reg        push_valid_reg;
  reg [`JOB_W-1:0] push_data_reg;
  reg [15:0] flash_mem [0:`FLASH_WORDS-1];
  reg [7:0]  ee_mem    [0:`EE_BYTES-1];
  reg [15:0] fbuf      [0:`PAGE_WORDS-1];
  reg [7:0]  ebuf      [0:`EE_PAGE_BYTES-1];
  reg [`EE_PAGE_BYTES-1:0] emask_reg;
  reg [7:0]  lock_reg, fuse_low_reg, fuse_high_reg, fuse_ext_reg;
  reg [1:0]  state_reg;
  reg [`FLASH_AW-1:0] erase_cnt_reg;
  reg [`TIMER_W-1:0]  timer_reg;
  wire       in_prog, sck_rise, sck_fall, byte_done;
  wire       push_ready, job_valid, job_ready, job_take, busy;
  wire [7:0] rx_byte, job_data, tx_next;
  wire [`JOB_W-1:0] job;
  wire [2:0] job_op;
  wire [12:0] job_addr, rd_waddr;
  wire [9:0] rd_eaddr;
  reg  [7:0] read_byte;
  integer    i;

  assign in_prog   = ~rst_sync_reg[1];
  assign prog_mode = in_prog;
  assign miso_oe_n = ~in_prog;
  assign sck_rise  = sck_sync_reg[1] & ~sck_sync_reg[2];
  assign sck_fall  = ~sck_sync_reg[1] & sck_sync_reg[2];
  assign rx_byte   = {rx_reg, mosi_sync_reg[1]};
  assign byte_done = in_prog && sck_rise && (bit_cnt_reg == 3'h7);
  assign rd_waddr  = {b2_reg[4:0], rx_byte};
  assign rd_eaddr  = {b2_reg[1:0], rx_byte};
  assign busy      = job_valid || (state_reg != ST_IDLE) ||
                     (timer_reg != {`TIMER_W{1'b0}});
  assign write_pending_flag = busy;

  // Fourth-byte answer, chosen while the third byte completes
  always @* begin
    read_byte = 8'h00;
    case (b1_reg)
      `INS_POLL:    read_byte = {7'h00, busy};
      `INS_RD_HI:   read_byte = flash_mem[rd_waddr][15:8];
      `INS_RD_LO:   read_byte = flash_mem[rd_waddr][7:0];
      `INS_RD_EE:   read_byte = ee_mem[rd_eaddr];
      `INS_RD_LOCK: read_byte = (b2_reg == `SEL_HIGH) ? fuse_high_reg
                                                      : lock_reg;
      `INS_RD_FUSE: read_byte = (b2_reg == `SEL_HIGH) ? fuse_ext_reg
                                                      : fuse_low_reg;
      `INS_RD_SIG: begin
        case (rx_byte[1:0])
          2'h0:    read_byte = SIGNATURE_0;
          2'h1:    read_byte = SIGNATURE_1;
          default: read_byte = SIGNATURE_2;
        endcase
      end
      `INS_RD_CAL:  read_byte = CALIBRATION;
      default:      read_byte = rx_byte;
    endcase
  end

  assign tx_next = (byte_idx_reg == 2'h3) ? 8'h00 :
                   (byte_idx_reg != 2'h2) ? rx_byte :
                   enabled_reg ? read_byte : rx_byte;

  // Pin inputs, two stages before use
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sck_sync_reg  <= 3'h0;
      mosi_sync_reg <= 2'h0;
      rst_sync_reg  <= 2'h3;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[1:0], sck_pin};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_pin};
      rst_sync_reg  <= {rst_sync_reg[0], prog_reset_n_pin};
    end
  end

  // Serial framing and instruction decode
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_reg         <= 7'h00;
      bit_cnt_reg    <= 3'h0;
      byte_idx_reg   <= 2'h0;
      b1_reg         <= 8'h00;
      b2_reg         <= 8'h00;
      b3_reg         <= 8'h00;
      tx_reg         <= 8'h00;
      tx_load_reg    <= 8'h00;
      tx_pending_reg <= 1'b0;
      enabled_reg    <= 1'b0;
      miso           <= 1'b0;
      push_valid_reg <= 1'b0;
      push_data_reg  <= {`JOB_W{1'b0}};
    end else begin
      push_valid_reg <= 1'b0;
      if (!in_prog) begin
        // Leaving the mode drops enable and byte framing
        bit_cnt_reg    <= 3'h0;
        byte_idx_reg   <= 2'h0;
        enabled_reg    <= 1'b0;
        tx_pending_reg <= 1'b0;
        miso           <= 1'b0;
      end else begin
        if (sck_rise) begin
          rx_reg      <= rx_byte[6:0];
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done) begin
          byte_idx_reg   <= byte_idx_reg + 2'h1;
          tx_load_reg    <= tx_next;
          tx_pending_reg <= 1'b1;
          case (byte_idx_reg)
            2'h0:    b1_reg <= rx_byte;
            2'h1:    b2_reg <= rx_byte;
            default: b3_reg <= rx_byte;
          endcase
        end
        if (sck_fall) begin
          if (tx_pending_reg) begin
            miso           <= tx_load_reg[7];
            tx_reg         <= {tx_load_reg[6:0], 1'b0};
            tx_pending_reg <= 1'b0;
          end else begin
            miso   <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
        if (byte_done && byte_idx_reg == 2'h3) begin
          // Full four-byte instruction in b1..b3 plus rx_byte
          if (b1_reg == `INS_PREFIX && b2_reg == `INS_ENABLE2) begin
            enabled_reg <= 1'b1;
          end else if (enabled_reg) begin
            push_data_reg[`JOB_ADDR] <= {b2_reg[4:0], b3_reg};
            push_data_reg[`JOB_DATA] <= rx_byte;
            push_valid_reg <= 1'b1;
            case (b1_reg)
              `INS_PREFIX: begin
                case (b2_reg)
                  `INS_ERASE2: push_data_reg[`JOB_OP] <= `OP_ERASE;
                  `INS_WLOCK2, `INS_WFUSE2, `INS_WFUSEH2, `INS_WFUSEX2: begin
                    push_data_reg[`JOB_OP] <= `OP_FUSE_WRITE;
                    push_data_reg[9:8] <= (b2_reg == `INS_WLOCK2) ? `FSEL_LOCK
                                        : (b2_reg == `INS_WFUSE2) ? `FSEL_LOW
                                        : (b2_reg == `INS_WFUSEH2) ? `FSEL_HIGH
                                        : `FSEL_EXT;
                  end
                  default: push_valid_reg <= 1'b0;
                endcase
              end
              `INS_LOAD_LO: push_data_reg[`JOB_OP] <= `OP_LOAD_LO;
              `INS_LOAD_HI: push_data_reg[`JOB_OP] <= `OP_LOAD_HI;
              `INS_EE_LOAD: push_data_reg[`JOB_OP] <= `OP_EE_LOAD;
              `INS_FLASH_COMMIT:
                push_data_reg[`JOB_OP] <= `OP_FLASH_COMMIT;
              `INS_EE_WRITE: push_data_reg[`JOB_OP] <= `OP_EE_WRITE;
              `INS_EE_COMMIT: push_data_reg[`JOB_OP] <= `OP_EE_COMMIT;
              // Single bank: extended address accepted, nothing to hold
              default: push_valid_reg <= 1'b0;
            endcase
          end
        end
      end
    end
  end

  // Jobs arriving while the queue is full are lost, as overrun while busy is
  job_fifo #(.WIDTH(`JOB_W), .DEPTH(`FIFO_DEPTH), .AW(3)) u_jobs (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (push_valid_reg),
    .in_ready  (push_ready),
    .in_data   (push_data_reg),
    .out_valid (job_valid),
    .out_ready (job_ready),
    .out_data  (job)
  );

  assign job_ready = (state_reg == ST_IDLE) &&
                     (timer_reg == {`TIMER_W{1'b0}});
  assign job_take  = job_valid && job_ready;
  assign job_op    = job[`JOB_OP];
  assign job_addr  = job[`JOB_ADDR];
  assign job_data  = job[`JOB_DATA];

  // Array contents carry no reset
  always @(posedge clock) begin
    if (state_reg == ST_ERASE) begin
      flash_mem[erase_cnt_reg] <= `ERASED_WORD;
      fbuf[erase_cnt_reg[`PAGE_AW-1:0]] <= `ERASED_WORD; // No X words
      if (erase_cnt_reg < `EE_BYTES) begin
        ee_mem[erase_cnt_reg[`EE_AW-1:0]] <= `ERASED_BYTE;
      end
    end
    if (job_take) begin
      case (job_op)
        `OP_LOAD_LO: fbuf[job_addr[`PAGE_AW-1:0]][7:0] <= job_data;
        `OP_LOAD_HI: fbuf[job_addr[`PAGE_AW-1:0]][15:8] <= job_data;
        `OP_EE_LOAD: ebuf[job_addr[`EE_PAGE_AW-1:0]] <= job_data;
        `OP_FLASH_COMMIT: begin
          for (i = 0; i < `PAGE_WORDS; i = i + 1) begin
            flash_mem[{job_addr[12:6], i[5:0]}] <= fbuf[i];
            fbuf[i] <= `ERASED_WORD;
          end
        end
        // Auto erase is implicit: the location is simply replaced
        `OP_EE_WRITE: ee_mem[job_addr[`EE_AW-1:0]] <= job_data;
        `OP_EE_COMMIT: begin
          for (i = 0; i < `EE_PAGE_BYTES; i = i + 1) begin
            if (emask_reg[i]) begin
              ee_mem[{job_addr[9:2], i[1:0]}] <= ebuf[i];
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Job sequencing, fuses and self-timed wait
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      erase_cnt_reg <= {`FLASH_AW{1'b0}};
      timer_reg     <= {`TIMER_W{1'b0}};
      emask_reg     <= {`EE_PAGE_BYTES{1'b0}};
      lock_reg      <= `LOCK_RESET;
      fuse_low_reg  <= `FUSE_LOW_RESET;
      fuse_high_reg <= `FUSE_HIGH_RESET;
      fuse_ext_reg  <= `FUSE_EXT_RESET;
    end else begin
      if (timer_reg != {`TIMER_W{1'b0}}) begin
        timer_reg <= timer_reg - 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (job_take) begin
            case (job_op)
              `OP_EE_LOAD:
                emask_reg[job_addr[`EE_PAGE_AW-1:0]] <= 1'b1;
              `OP_FLASH_COMMIT: timer_reg <= FLASH_WAIT_CYCLES;
              `OP_EE_WRITE: timer_reg <= EEPROM_WAIT_CYCLES;
              `OP_EE_COMMIT: begin
                emask_reg <= {`EE_PAGE_BYTES{1'b0}};
                timer_reg <= EEPROM_WAIT_CYCLES;
              end
              `OP_ERASE: begin
                state_reg     <= ST_ERASE;
                erase_cnt_reg <= {`FLASH_AW{1'b0}};
                lock_reg      <= `LOCK_RESET;
              end
              `OP_FUSE_WRITE: begin
                timer_reg <= EEPROM_WAIT_CYCLES;
                case (job_addr[1:0])
                  // Lock bits only program; erase clears them
                  `FSEL_LOCK: lock_reg <= lock_reg & job_data;
                  `FSEL_LOW:  fuse_low_reg  <= job_data;
                  `FSEL_HIGH: fuse_high_reg <= job_data;
                  default:    fuse_ext_reg  <= job_data;
                endcase
              end
              default: ;
            endcase
          end
        end
        ST_ERASE: begin
          erase_cnt_reg <= erase_cnt_reg + 1'b1;
          if (erase_cnt_reg == `FLASH_WORDS - 1) begin
            state_reg <= ST_IDLE;
            timer_reg <= ERASE_WAIT_CYCLES;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // serial_prog_port

//--- spp_asserts.sv
`timescale 1ns/1ps
module spp_checker #(
  parameter int ERASE_WAIT_CYCLES = 1800000
) (
  input wire clock,
  input wire reset,
  input wire prog_reset_n_pin,
  input wire sck_pin,
  input wire mosi_pin,
  input wire miso,
  input wire miso_oe_n,
  input wire prog_mode,
  input wire write_pending_flag
);
  // Loose ceiling: nine queued jobs, each no longer than an erase
  localparam int PEND_LIMIT = 9 * (ERASE_WAIT_CYCLES + 8256);
  logic [31:0] pend_cnt_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  always @(posedge clock or posedge reset) begin
    if (reset)
      pend_cnt_reg <= 32'h0;
    else if (write_pending_flag)
      pend_cnt_reg <= pend_cnt_reg + 32'h1;
    else
      pend_cnt_reg <= 32'h0;
  end

  AST_OE_MATCHES_MODE:
    assert property (miso_oe_n != prog_mode)
      else $error("miso enable and mode disagree");
  AST_MODE_ENTER:
    assert property (!prog_reset_n_pin [*4] |-> prog_mode)
      else $error("mode not entered with pin low");
  AST_MODE_EXIT:
    assert property (prog_reset_n_pin [*4] |-> !prog_mode)
      else $error("mode kept with pin high");
  AST_MISO_QUIET:
    assert property (!prog_mode [*2] |-> !miso)
      else $error("miso active out of mode");
  AST_MISO_ON_FALL:
    assert property (prog_mode && $past(prog_mode) && $changed(miso)
                     |-> !sck_pin && !$past(sck_pin, 2))
      else $error("miso moved away from a falling edge");
  AST_MISO_STILL_HIGH:
    assert property (prog_mode && sck_pin && $past(sck_pin)
                     |-> $stable(miso))
      else $error("miso moved while serial clock high");
  AST_PEND_GAP:
    assert property ($fell(write_pending_flag)
                     |-> !write_pending_flag [*8])
      else $error("pending flag rose again without a new instruction");
  AST_PEND_AFTER_RISE:
    assert property ($rose(write_pending_flag)
                     |-> $past(sck_pin, 4) && prog_mode)
      else $error("write started off an instruction end");
  AST_PEND_BOUNDED:
    assert property (pend_cnt_reg <= PEND_LIMIT)
      else $error("pending flag stuck");
endmodule // spp_checker

bind serial_prog_port spp_checker #(
  .ERASE_WAIT_CYCLES(ERASE_WAIT_CYCLES)
) chk_u (
  .clock(clock), .reset(reset), .prog_reset_n_pin(prog_reset_n_pin),
  .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso(miso),
  .miso_oe_n(miso_oe_n), .prog_mode(prog_mode),
  .write_pending_flag(write_pending_flag)
);

//--- prog_host.sv
`timescale 1ns/1ps
module prog_host (
  output logic prog_reset_n_pin,
  output logic sck_pin,
  output logic mosi_pin,
  input  wire  miso
);
  initial begin
    prog_reset_n_pin = 1'b1;
    sck_pin = 1'b0;
    mosi_pin = 1'b0;
  end

  task automatic pin(input logic v, input int ns);
    prog_reset_n_pin = v;
    #(ns);
  endtask

  // 64 ns link period, unrelated to the core clock
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_pin = tx[i];
      #32 sck_pin = 1'b1;
      rx[i] = miso;
      #32 sck_pin = 1'b0;
    end
  endtask
endmodule // prog_host

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0]  SIG [4]    = '{8'h3C, 8'h11, 8'h22, 8'h22};
  localparam logic [7:0]  WR_SEL [4] = '{8'hA0, 8'hA8, 8'hA4, 8'hE0};
  localparam logic [15:0] RD_SEL [4] = '{16'h5000, 16'h5808, 16'h5008,
                                         16'h5800};
  logic        clock;
  logic        reset;
  logic [31:0] lfsr_reg;
  logic [31:0] rx;
  logic [15:0] wa;
  logic [9:0]  a;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic [7:0]  mem [16];
  int          n_errors;
  int          check_count;
  int          hits;
  wire         rst_n_pin;
  wire         sck;
  wire         mosi;
  wire         miso;
  wire         miso_oe_n;
  wire         prog_mode;
  wire         pend;
  wire         miso_line;

  // Modelled pull-up on the line, so a released pin reads high here
  assign miso_line = miso_oe_n ? 1'b1 : miso;
  always #2.5 clock = ~clock;

  // Shortened wait times and arbitrary identity values
  serial_prog_port #(
    .FLASH_WAIT_CYCLES (21'h14),
    .EEPROM_WAIT_CYCLES(21'h7D0),
    .ERASE_WAIT_CYCLES (21'h28),
    .SIGNATURE_0       (SIG[0]),
    .SIGNATURE_1       (SIG[1]),
    .SIGNATURE_2       (SIG[2]),
    .CALIBRATION       (8'h6B)
  ) dut_u (
    .clock(clock), .reset(reset), .prog_reset_n_pin(rst_n_pin),
    .sck_pin(sck), .mosi_pin(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .prog_mode(prog_mode),
    .write_pending_flag(pend)
  );
  prog_host host_u (
    .prog_reset_n_pin(rst_n_pin), .sck_pin(sck), .mosi_pin(mosi),
    .miso(miso_line)
  );

  function automatic logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[30:0],
                lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    return lfsr_reg[7:0];
  endfunction
  function automatic logic [7:0] lock_exp(input logic [7:0] was, now);
    return was & now;
  endfunction
  task automatic chk8(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic ins(input logic [31:0] word);
    host_u.xfer(word, rx);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200; i++) begin
      ins(32'hF0000000);
      if (rx[0] === 1'b0)
        return;
    end
    chk1("poll status", 1'b0, rx[0]);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole sequence needs about 400 us of transfers and polls
  initial begin
    #480000;
    n_errors++;
    final_report();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    lfsr_reg = 32'h0001429B;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk1("oe_n out of mode", 1'b1, miso_oe_n);
    #1 host_u.pin(1'b0, 400);
    chk1("mode entry", 1'b1, prog_mode);
    ins(32'hC0010255);
    chk1("write before enable", 1'b0, pend);
    ins(32'hA0000533);
    chk8("read before enable", 8'h05, rx[7:0]);
    ins(32'hAC530000);
    chk8("enable echo", 8'h53, rx[15:8]);
    chk8("first byte echo", 8'hAC, rx[23:16]);
    ins(32'hAC800000);
    chk1("busy flag", 1'b1, pend);
    ins(32'hF0000000);
    chk1("poll busy", 1'b1, rx[0]);
    wait_idle();
    for (int i = 0; i < 2; i++) begin
      wa = {rnd(), rnd()};
      ins({8'h20, 3'h0, wa[12:0], 8'h00});
      chk8("erased flash", 8'hFF, rx[7:0]);
      ins({8'hA0, 6'h00, wa[9:0], 8'h00});
      chk8("erased eeprom", 8'hFF, rx[7:0]);
    end
    wa = {rnd(), rnd()};
    mem[8] = 8'hFF;
    mem[9] = 8'hFF;
    for (int i = 0; i < 4; i++) begin
      mem[2*i] = rnd();
      mem[2*i+1] = rnd();
      ins({8'h40, 8'h00, 2'h0, 6'(i*21), mem[2*i]});
      ins({8'h48, 8'h00, 2'h0, 6'(i*21), mem[2*i+1]});
    end
    ins({8'h4C, 3'h0, wa[12:6], 6'h00, 8'h00});
    wait_idle();
    for (int i = 0; i < 5; i++) begin
      ins({8'h20, 3'h0, wa[12:6], 6'(i*21), 8'h00});
      chk8("flash low", mem[2*i], rx[7:0]);
      ins({8'h28, 3'h0, wa[12:6], 6'(i*21), 8'h00});
      chk8("flash high", mem[2*i+1], rx[7:0]);
    end
    wa = {rnd(), rnd()};
    a = wa[9:0];
    d1 = rnd();
    d2 = ~d1;
    ins({8'hC0, 6'h00, a, d1});
    wait_idle();
    ins({8'hC0, 6'h00, a, d2});
    wait_idle();
    ins({8'hA0, 6'h00, a, 8'h00});
    chk8("eeprom rewrite", d2, rx[7:0]);
    ins({8'hC1, 14'h0000, a[1:0] ^ 2'h1, d1});
    ins({8'hC1, 14'h0000, a[1:0] ^ 2'h2, d1 ^ 8'h5A});
    ins({8'hC2, 6'h00, a[9:2], 2'h0, 8'h00});
    wait_idle();
    mem[0] = d2;
    mem[1] = d1;
    mem[2] = d1 ^ 8'h5A;
    mem[3] = 8'hFF;
    for (int i = 0; i < 4; i++) begin
      ins({8'hA0, 6'h00, a[9:2], 2'(i) ^ a[1:0], 8'h00});
      chk8("eeprom page", mem[i], rx[7:0]);
    end
    host_u.pin(1'b1, 100);
    chk1("mode exit", 1'b0, prog_mode);
    host_u.pin(1'b0, 400);
    ins(32'hAC530000);
    chk8("retry echo", 8'h53, rx[15:8]);
    for (int k = 0; k < 4; k++) begin
      d1 = rnd();
      ins({8'hAC, WR_SEL[k], 8'h00, d1});
      wait_idle();
      ins({RD_SEL[k], 16'h0000});
      chk8("fuse readback", d1, rx[7:0]);
    end
    d2 = rnd();
    ins({8'hAC, 8'hE0, 8'h00, d2});
    wait_idle();
    ins(32'h58000000);
    chk8("lock programs only", lock_exp(d1, d2), rx[7:0]);
    for (int k = 0; k < 4; k++) begin
      ins({8'h30, 8'h00, 8'(k), 8'h00});
      chk8("signature", SIG[k], rx[7:0]);
    end
    ins(32'h38000000);
    chk8("calibration", 8'h6B, rx[7:0]);
    // Writes sent without waiting, to overrun the job queue
    for (int i = 0; i < 14; i++) begin
      mem[i] = rnd() >> 1;
      ins({8'hC0, 6'h00, a[9:4] ^ 6'h20, 4'(i), mem[i]});
    end
    wait_idle();
    hits = 0;
    for (int i = 0; i < 14; i++) begin
      ins({8'hA0, 6'h00, a[9:4] ^ 6'h20, 4'(i), 8'h00});
      if (i < 9)
        chk8("queued write", mem[i], rx[7:0]);
      hits += int'(rx[7:0] === mem[i]);
    end
    chk1("full queue drops", 1'b1, hits < 14);
    final_report();
  end
endmodule // tb_top
